// ===== pkg/csp_regs.vh
// Register map, field positions and timing constants of the clocked serial port
`ifndef CSP_REGS_VH
`define CSP_REGS_VH

// Byte offsets inside one channel window; paddr[6] picks the channel
`define CSP_OFF_MODE 6'h00
`define CSP_OFF_CLKSEL 6'h04
`define CSP_OFF_SHIFT 6'h08
`define CSP_OFF_SHIFT_LOW 6'h0C
`define CSP_OFF_RXB 6'h10
`define CSP_OFF_RXB_LOW 6'h14
`define CSP_OFF_RXM 6'h18
`define CSP_OFF_RXM_LOW 6'h1C
`define CSP_OFF_TXB 6'h20
`define CSP_OFF_TXB_LOW 6'h24
`define CSP_OFF_ITXB 6'h28
`define CSP_OFF_ITXB_LOW 6'h2C
`define CSP_OFF_LAST 6'h2C
`define CSP_CH_BIT 6
`define CSP_TOP_BIT 7

// Mode register fields
`define CSP_MODE_EN 7
`define CSP_MODE_DUPLEX 6
`define CSP_MODE_LEN16 5
`define CSP_MODE_LSB 4
`define CSP_MODE_IRQDLY 3
`define CSP_MODE_CONT 2
`define CSP_MODE_BUSY 0
`define CSP_MODE_RST 8'h00
`define CSP_MODE_WMASK 8'hFC

// Clock select: codes 0..6 internal, 7 external pin
`define CSP_CLKSEL_EXT 3'h7
`define CSP_CLKSEL_RST 3'h0

// Word lengths in shift clocks
`define CSP_BITS_8 5'h08
`define CSP_BITS_16 5'h10

// Timing: 5 Mbps ceiling gives a 200 ns bit
`define CSP_PCLK_NS 5
`define CSP_MIN_BIT_NS 200
`define CSP_HALF_BASE_CYC ((`CSP_MIN_BIT_NS / 2 + `CSP_PCLK_NS - 1) / `CSP_PCLK_NS)
`define CSP_IRQ_DELAY_NS 100
`define CSP_IRQ_DELAY_CYC ((`CSP_IRQ_DELAY_NS + `CSP_PCLK_NS - 1) / `CSP_PCLK_NS)

`endif

// ===== logic/csp_shift.v
// Shift engine of one channel: clock generation, bit counter and shared shift register
`timescale 1ns/1ps
`default_nettype none
`include "csp_regs.vh"

module csp_shift #(
    parameter WIDTH = 16,
    parameter CW = 11
) (
    input wire pclk, // Peripheral clock
    input wire presetn, // Async reset, active low
    input wire ce, // Clock enable
    input wire en, // Channel enable
    input wire start, // Begin one word
    input wire [WIDTH-1:0] start_word, // Word to send
    input wire load, // Bus write to shift register
    input wire [WIDTH-1:0] load_word, // Data for that write
    input wire len16, // 16-bit words
    input wire lsb_first, // LSB goes first
    input wire duplex, // Transmit and receive
    input wire [2:0] div_sel, // Clock source
    input wire sck_pin, // Clock pin level, async
    input wire si_pin, // Data pin level, async
    output reg busy, // Word in flight
    output reg done, // Word finished, pulse
    output reg [WIDTH-1:0] shreg, // Shared shift register
    output reg sck_r, // Driven clock level
    output reg so_r // Data out level
);
    localparam H = WIDTH / 2;
    localparam integer HALF_BASE_I = `CSP_HALF_BASE_CYC;
    localparam [CW-1:0] HALF_BASE = HALF_BASE_I[CW-1:0]; // Cut on purpose, base fits the counter

    reg sck_s1, sck_s2, sck_s3, si_s1, si_s2;
    reg [CW-1:0] cnt_r;
    reg [4:0] bit_r;
    wire ext = (div_sel == `CSP_CLKSEL_EXT);
    wire [CW-1:0] half_w = HALF_BASE << div_sel;
    wire tick = busy & ~ext & (cnt_r == {CW{1'b0}});
    wire rise = busy & (ext ? (sck_s2 & ~sck_s3) : (tick & ~sck_r));
    wire fall = busy & (ext ? (~sck_s2 & sck_s3) : (tick & sck_r));
    wire [4:0] len_w = len16 ? `CSP_BITS_16 : `CSP_BITS_8;
    wire [4:0] bit_inc = bit_r + 5'h01;

    // Shift one received bit in at the chosen end, 8-bit view uses low byte
    function [WIDTH-1:0] sh_fn;
        input [WIDTH-1:0] sr;
        input b;
        input l16;
        input lsb;
        begin
            sh_fn = sr;
            if (l16 & ~lsb)
                sh_fn = {sr[WIDTH-2:0], b};
            else if (l16)
                sh_fn = {b, sr[WIDTH-1:1]};
            else if (~lsb)
                sh_fn[H-1:0] = {sr[H-2:0], b};
            else
                sh_fn[H-1:0] = {b, sr[H-1:1]};
        end
    endfunction

    // Bit that goes out next
    function out_fn;
        input [WIDTH-1:0] sr;
        input l16;
        input lsb;
        begin
            out_fn = lsb ? sr[0] : (l16 ? sr[WIDTH-1] : sr[H-1]);
        end
    endfunction

    // Pin synchronisers; the second stages are looked at, and the clock's third stage too for edges
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_s1 <= 1'b1;
            sck_s2 <= 1'b1;
            sck_s3 <= 1'b1;
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
        end
        else if (ce)
        begin
            sck_s1 <= sck_pin;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            si_s1 <= si_pin;
            si_s2 <= si_s1;
        end
    end

    // Clock, counter and shift; idle clock high, out on fall, sample on rise
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            shreg <= {WIDTH{1'b0}};
            sck_r <= 1'b1;
            so_r <= 1'b0;
            cnt_r <= {CW{1'b0}};
            bit_r <= 5'h00;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (!en)
            begin
                busy <= 1'b0;
                sck_r <= 1'b1;
                so_r <= 1'b0;
                bit_r <= 5'h00;
            end
            else if (start)
            begin
                busy <= 1'b1;
                shreg <= start_word;
                bit_r <= 5'h00;
                cnt_r <= half_w - 1'b1;
                so_r <= duplex & out_fn(start_word, len16, lsb_first);
            end
            else if (busy)
            begin
                if (tick)
                begin
                    sck_r <= ~sck_r;
                    cnt_r <= half_w - 1'b1;
                end
                else if (!ext)
                    cnt_r <= cnt_r - 1'b1;
                if (fall)
                    so_r <= duplex & out_fn(shreg, len16, lsb_first);
                if (rise)
                begin
                    shreg <= sh_fn(shreg, si_s2, len16, lsb_first);
                    bit_r <= bit_inc;
                    if (bit_inc == len_w)
                    begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
            end
            else
            begin
                sck_r <= 1'b1;
                if (load)
                    shreg <= load_word;
            end
        end
    end
endmodule // csp_shift

`default_nettype wire

// ===== logic/csp_top.v
// Two-channel clocked serial port with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "csp_regs.vh"

module csp_top #(
    parameter NCH = 2,
    parameter WIDTH = 16,
    parameter AW = 8
) (
    input wire pclk, // APB clock, 200 MHz
    input wire presetn, // Async reset, active low
    input wire pce, // Clock enable, freezes all
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [AW-1:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire [31:0] prdata, // APB read data, registered
    output wire pready, // APB ready
    output wire pslverr, // Unmapped address
    input wire [NCH-1:0] shift_clock_pin_i, // Clock pin level
    output wire [NCH-1:0] shift_clock_pin_o, // Clock pin drive
    output wire [NCH-1:0] shift_clock_pin_oe, // Clock pin enable
    input wire [NCH-1:0] serial_data_in, // Data in pins
    output wire [NCH-1:0] serial_data_out, // Data out pins
    output wire [NCH-1:0] transfer_done_irq // Completion pulse
);
    localparam [AW-1:0] ZERO_A = {AW{1'b0}};

    reg [31:0] prdata_r;
    reg cap_r;
    wire [32*NCH-1:0] rd_all;
    wire [5:0] off = paddr[5:0];
    wire ch_sel = paddr[`CSP_CH_BIT];
    wire addr_ok;
    wire acc_done;
    wire wr_acc;
    wire rd_acc;

    // Address check, shared by error answer and read mux
    function csp_valid;
        input [AW-1:0] a;
        begin
            csp_valid = (a[AW-1:`CSP_TOP_BIT] == ZERO_A[AW-1:`CSP_TOP_BIT])
                && (a[5:0] <= `CSP_OFF_LAST) && (a[1:0] == 2'b00);
        end
    endfunction

    assign addr_ok = csp_valid(paddr);

    // Zero wait states once setup was seen under the clock enable
    assign pready = cap_r & pce;
    assign acc_done = psel & penable & pready;
    assign wr_acc = acc_done & pwrite & addr_ok;
    assign rd_acc = acc_done & ~pwrite & addr_ok;
    assign pslverr = acc_done & ~addr_ok;
    assign prdata = prdata_r;

    // Read data is taken in the setup phase so it comes from a flop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h00000000;
            cap_r <= 1'b0;
        end
        else if (pce)
        begin
            if (psel & ~penable)
            begin
                cap_r <= 1'b1;
                if (!pwrite && addr_ok)
                    prdata_r <= ch_sel ? rd_all[63:32] : rd_all[31:0];
                else
                    prdata_r <= 32'h00000000;
            end
            else if (acc_done)
                cap_r <= 1'b0;
        end
    end

    genvar ch;
    // Identical channels, each with its own registers and engine
    generate
        for (ch = 0; ch < NCH; ch = ch + 1)
        begin : gen_ch
            reg [7:0] mode_r;
            reg [2:0] clksel_r;
            reg [WIDTH-1:0] txb_r;
            reg [WIDTH-1:0] itxb_r;
            reg [WIDTH-1:0] rxb_r;
            reg [WIDTH-1:0] sword_r;
            reg pend_r;
            reg chain_r;
            reg start_r;
            reg irq_r;
            reg dly_run_r;
            reg [7:0] dly_r;
            reg [31:0] rd_w;
            wire busy_w;
            wire done_w;
            wire [WIDTH-1:0] sh_w;
            wire sck_w;
            wire so_w;
            wire hit = (ch_sel == ch);
            wire en = mode_r[`CSP_MODE_EN];
            wire duplex = mode_r[`CSP_MODE_DUPLEX];
            wire cont = mode_r[`CSP_MODE_CONT];
            wire ext = (clksel_r == `CSP_CLKSEL_EXT);
            wire in_flight = busy_w | start_r;
            wire wr_hit = wr_acc & hit;
            wire rd_hit = rd_acc & hit;
            wire tx_wr = wr_hit & duplex & ((off == `CSP_OFF_TXB) | (off == `CSP_OFF_TXB_LOW));
            wire rx_rd = rd_hit & ~duplex & ((off == `CSP_OFF_RXB) | (off == `CSP_OFF_RXB_LOW));
            wire req = tx_wr | rx_rd;
            // Single mode ignores a request that arrives while busy
            wire pend_set = en & req & (cont | (~in_flight & ~pend_r));
            wire issue = en & pend_r & ~in_flight;
            // First word of a continuous duplex chain keeps the request queued
            wire first_cont = cont & ~chain_r & duplex;
            wire sh_load = wr_hit & ~in_flight
                & ((off == `CSP_OFF_SHIFT) | (off == `CSP_OFF_SHIFT_LOW));
            wire [WIDTH-1:0] sh_data = (off == `CSP_OFF_SHIFT_LOW)
                ? {sh_w[WIDTH-1:8], pwdata[7:0]} : pwdata[WIDTH-1:0];
            localparam integer DLY_CYC_I = `CSP_IRQ_DELAY_CYC;
            localparam [7:0] DLY_CYC = DLY_CYC_I[7:0];

            // Mode and clock select registers
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    mode_r <= `CSP_MODE_RST;
                    clksel_r <= `CSP_CLKSEL_RST;
                end
                else if (pce && wr_hit)
                begin
                    // Changing fields mid-word is software's problem, not checked here
                    if (off == `CSP_OFF_MODE)
                        mode_r <= pwdata[7:0] & `CSP_MODE_WMASK;
                    if (off == `CSP_OFF_CLKSEL)
                        clksel_r <= pwdata[2:0];
                end
            end

            // Transmit and initial transmit buffers with low-byte views
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    txb_r <= {WIDTH{1'b0}};
                    itxb_r <= {WIDTH{1'b0}};
                end
                else if (pce && wr_hit)
                begin
                    if (off == `CSP_OFF_TXB)
                        txb_r <= pwdata[WIDTH-1:0];
                    if (off == `CSP_OFF_TXB_LOW)
                        txb_r[7:0] <= pwdata[7:0];
                    if (off == `CSP_OFF_ITXB)
                        itxb_r <= pwdata[WIDTH-1:0];
                    if (off == `CSP_OFF_ITXB_LOW)
                        itxb_r[7:0] <= pwdata[7:0];
                end
            end

            // Start sequencing; a new request wins over the clear
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pend_r <= 1'b0;
                    chain_r <= 1'b0;
                    start_r <= 1'b0;
                    sword_r <= {WIDTH{1'b0}};
                end
                else if (pce)
                begin
                    start_r <= 1'b0;
                    if (!en)
                    begin
                        pend_r <= 1'b0;
                        chain_r <= 1'b0;
                    end
                    else
                    begin
                        if (issue)
                        begin
                            start_r <= 1'b1;
                            chain_r <= cont;
                            sword_r <= first_cont ? itxb_r : txb_r;
                            if (!first_cont)
                                pend_r <= 1'b0;
                        end
                        else if (done_w && !pend_r)
                            chain_r <= 1'b0;
                        if (pend_set)
                            pend_r <= 1'b1;
                    end
                end
            end

            // Receive buffer takes each finished word
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    rxb_r <= {WIDTH{1'b0}};
                else if (pce && done_w)
                    rxb_r <= mode_r[`CSP_MODE_LEN16] ? sh_w : {8'h00, sh_w[7:0]};
            end

            // Completion interrupt, optionally held back by a fixed delay
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    irq_r <= 1'b0;
                    dly_run_r <= 1'b0;
                    dly_r <= 8'h00;
                end
                else if (pce)
                begin
                    irq_r <= 1'b0;
                    if (!en)
                        dly_run_r <= 1'b0;
                    else if (done_w && !mode_r[`CSP_MODE_IRQDLY])
                        irq_r <= 1'b1;
                    else if (done_w)
                    begin
                        dly_run_r <= 1'b1;
                        dly_r <= DLY_CYC - 8'h01;
                    end
                    else if (dly_run_r && dly_r == 8'h00)
                    begin
                        dly_run_r <= 1'b0;
                        irq_r <= 1'b1;
                    end
                    else if (dly_run_r)
                        dly_r <= dly_r - 8'h01;
                end
            end

            // Register read mux; mirrors read the same data without side effect
            always @*
            begin
                rd_w = 32'h00000000;
                case (off)
                    `CSP_OFF_MODE: rd_w[7:0] = {mode_r[7:1], in_flight};
                    `CSP_OFF_CLKSEL: rd_w[2:0] = clksel_r;
                    `CSP_OFF_SHIFT: rd_w[WIDTH-1:0] = sh_w;
                    `CSP_OFF_SHIFT_LOW: rd_w[7:0] = sh_w[7:0];
                    `CSP_OFF_RXB: rd_w[WIDTH-1:0] = rxb_r;
                    `CSP_OFF_RXB_LOW: rd_w[7:0] = rxb_r[7:0];
                    `CSP_OFF_RXM: rd_w[WIDTH-1:0] = rxb_r;
                    `CSP_OFF_RXM_LOW: rd_w[7:0] = rxb_r[7:0];
                    `CSP_OFF_TXB: rd_w[WIDTH-1:0] = txb_r;
                    `CSP_OFF_TXB_LOW: rd_w[7:0] = txb_r[7:0];
                    `CSP_OFF_ITXB: rd_w[WIDTH-1:0] = itxb_r;
                    `CSP_OFF_ITXB_LOW: rd_w[7:0] = itxb_r[7:0];
                    default: rd_w = 32'h00000000;
                endcase
            end

            assign rd_all[32*ch +: 32] = rd_w;

            // Pins: internal clock drives, external clock leaves the pin alone
            assign shift_clock_pin_o[ch] = sck_w;
            assign shift_clock_pin_oe[ch] = en & ~ext;
            assign serial_data_out[ch] = so_w;
            assign transfer_done_irq[ch] = irq_r;

            csp_shift #(
                .WIDTH(WIDTH),
                .CW(11)
            ) u_shift (
                .pclk(pclk),
                .presetn(presetn),
                .ce(pce),
                .en(en),
                .start(start_r),
                .start_word(sword_r),
                .load(sh_load),
                .load_word(sh_data),
                .len16(mode_r[`CSP_MODE_LEN16]),
                .lsb_first(mode_r[`CSP_MODE_LSB]),
                .duplex(duplex),
                .div_sel(clksel_r),
                .sck_pin(shift_clock_pin_i[ch]),
                .si_pin(serial_data_in[ch]),
                .busy(busy_w),
                .done(done_w),
                .shreg(sh_w),
                .sck_r(sck_w),
                .so_r(so_w)
            );
        end
    endgenerate
endmodule // csp_top

`default_nettype wire

// ===== tb/csp_properties.sv
// Port-level timing checker for the clocked serial port
`timescale 1ns/1ps
`default_nettype none
module csp_properties #(parameter NCH = 2, parameter AW = 8) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic pce, // Clock enable
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [AW-1:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [NCH-1:0] shift_clock_pin_i, // Pin in
    input wire logic [NCH-1:0] shift_clock_pin_o, // Pin drive
    input wire logic [NCH-1:0] shift_clock_pin_oe, // Pin enable
    input wire logic [NCH-1:0] serial_data_in, // Data in
    input wire logic [NCH-1:0] serial_data_out, // Data out
    input wire logic [NCH-1:0] transfer_done_irq // Done
);
    logic [7:0] hold_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Age of the clock level; saturates so long idles never wrap
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_r <= 8'hFF;
        else if ($changed(shift_clock_pin_o[0]))
            hold_r <= 8'h01;
        else if (hold_r != 8'hFF)
            hold_r <= hold_r + 8'h01;
    end
    chk_apb_nowait: assert property (psel && !penable && pce ##1 psel && penable && pce |-> pready)
        else $error("late ready");
    chk_pready_frozen: assert property (!pce |-> !pready)
        else $error("ready while frozen");
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("stray error");
    chk_err_rdzero: assert property (psel && penable && pready && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("error read not zero");
    chk_irq_pulse: assert property (transfer_done_irq[0] |=> !transfer_done_irq[0])
        else $error("long interrupt");
    chk_reset_pins: assert property ($rose(presetn) |-> shift_clock_pin_o == 2'h3 && shift_clock_pin_oe == 2'h0
        && serial_data_out == 2'h0 && transfer_done_irq == 2'h0)
        else $error("pins after reset");
    chk_bit_rate: assert property ($changed(shift_clock_pin_o[0]) && shift_clock_pin_oe[0] |-> hold_r >= 8'h14)
        else $error("clock too fast");
    chk_data_stable: assert property (shift_clock_pin_oe[0] && $rose(shift_clock_pin_o[0])
        |-> $stable(serial_data_out[0]))
        else $error("data moved at sample");
    chk_idle_high: assert property ($rose(shift_clock_pin_oe[0]) |-> shift_clock_pin_o[0])
        else $error("drive began low");
endmodule // csp_properties
bind csp_top csp_properties #(.NCH(NCH), .AW(AW)) chk (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .shift_clock_pin_i, .shift_clock_pin_o, .shift_clock_pin_oe,
    .serial_data_in, .serial_data_out, .transfer_done_irq);
`default_nettype wire

// ===== tb/csp_peer.sv
// Serial peer: slave to the port's clock, or master at 48 ns when the port is clocked from the pin
`timescale 1ns/1ps
`default_nettype none
module csp_peer (
    input wire logic pclk, // Clock for line noise
    input wire logic clk_o, // Port clock drive
    input wire logic clk_oe, // Port drives clock
    input wire logic so, // Port data out
    output logic pin, // Resolved clock pin
    output logic si // Data to port
);
    logic [31:0] tx, rx;
    logic mclk = 1'b1;
    logic lsb;
    int n, fc, rc, idle;
    initial si = 1'b0;
    // Our clock rests high between frames, so the pin is still
    assign pin = clk_oe ? clk_o : mclk;
    task arm(input logic [31:0] w, input int bits, input logic l);
        tx = w;
        n = bits;
        lsb = l;
        fc = 0;
        rc = 0;
        rx = 32'h0;
    endtask
    task frame();
        repeat (n)
        begin
            #24 mclk = 1'b0;
            #24 mclk = 1'b1;
        end
    endtask
    // Next bit out on each fall
    always @(negedge pin)
        if (fc < n)
        begin
            si <= tx[lsb ? fc : n - 1 - fc];
            fc <= fc + 1;
        end
    // Port data taken on each rise
    always @(posedge pin)
        if (rc < n)
        begin
            rx[lsb ? rc : n - 1 - rc] <= so;
            rc <= rc + 1;
        end
    // Released line carries noise, so a late sample cannot pass by luck
    always @(posedge pclk)
    begin
        idle <= (rc < n) ? 0 : idle + 1;
        if (idle > 8)
            si <= ~si;
    end
endmodule // csp_peer
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the two-channel clocked serial port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, pce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr;
    logic [1:0] pin, cko, cke, sdi, sdo, irq;
    int error_cnt = 0, tests_run = 0, cyc = 0, icnt[2] = '{0, 0};
    csp_top uut (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .shift_clock_pin_i(pin), .shift_clock_pin_o(cko), .shift_clock_pin_oe(cke), .serial_data_in(sdi),
        .serial_data_out(sdo), .transfer_done_irq(irq));
    csp_peer p0 (.pclk, .clk_o(cko[0]), .clk_oe(cke[0]), .so(sdo[0]), .pin(pin[0]), .si(sdi[0]));
    csp_peer p1 (.pclk, .clk_o(cko[1]), .clk_oe(cke[1]), .so(sdo[1]), .pin(pin[1]), .si(sdi[1]));
    always #2.5 pclk = ~pclk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog sized for the slowest clock rates, plus completion pulse counts
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            error_cnt++;
            close_out();
        end
        foreach (icnt[i])
            if (irq[i] === 1'b1)
                icnt[i] <= icnt[i] + 1;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; request held until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask
    function automatic logic [31:0] fold(input logic [31:0] v, input int n);
        return n > 31 ? v : v & ((32'h1 << n) - 32'h1);
    endfunction
    // One word, or a chain of two, on channel c; continuous sends initial buffer first
    task automatic xfer(input int c, input logic [2:0] sel, input logic [7:0] m, input logic [31:0] tw, pw);
        logic [7:0] o;
        int w, b, k0, k1;
        o = c ? 8'h40 : 8'h00;
        w = m[2] ? 2 : 1;
        b = (m[5] ? 16 : 8) * w;
        k0 = icnt[c];
        k1 = icnt[1 - c];
        wr(o | 8'h04, {29'h0, sel});
        wr(o, {24'h0, m});
        if (c)
            p1.arm(pw, b, m[4]);
        else
            p0.arm(pw, b, m[4]);
        if (!m[6])
            apb(1'b0, o | 8'h10, 32'h0);
        else if (m[2])
            wr(o | 8'h28, tw[31:16]);
        if (m[6])
            wr(o | 8'h20, m[2] ? tw[15:0] : tw);
        rdc("busy", o, m | 8'h01);
        chk("drive", cke[c], sel != 3'h7);
        if (sel == 3'h7)
        begin
            repeat (8) @(posedge pclk);
            if (c)
                p1.frame();
            else
                p0.frame();
        end
        while (icnt[c] < k0 + w)
            @(posedge pclk);
        repeat (40) @(posedge pclk);
        chk("irqs", icnt[c] - k0, w);
        chk("other", icnt[1 - c], k1);
        rdc("idle", o, m);
        rdc("mirror", o | 8'h18, fold(pw, b > 16 ? 16 : b));
        rdc("mirror_low", o | 8'h1C, pw[7:0]);
        if (m[6])
            rdc("rxbuf", o | 8'h10, fold(pw, b > 16 ? 16 : b));
        chk("peer", c ? p1.rx : p0.rx, m[6] ? fold(tw, b) : 32'h0);
        wr(o, 32'h0);
        $display("test ch%0d sel %0d mode %h over", c, sel, m);
    endtask
    initial
    begin
        void'($urandom(24886));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc("mode", 8'h00, 32'h0);
        rdc("clksel", 8'h44, 32'h0);
        chk("pins", {cko, cke, sdo, irq}, 32'hC0);
        apb(1'b0, 8'h80, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        wr(8'h00, 32'hFF);
        rdc("mode_ro", 8'h00, 32'hFC);
        wr(8'h00, 32'hC0);
        wr(8'h08, 32'hA5A5);
        rdc("shift", 8'h08, 32'hA5A5);
        wr(8'h0C, 32'h5A);
        rdc("shift_low", 8'h08, 32'hA55A);
        repeat (100) @(posedge pclk);
        chk("no_start", icnt[0], 0);
        rdc("not_busy", 8'h00, 32'hC0);
        wr(8'h00, 32'h0);
        pce <= 1'b0;
        repeat (3) @(posedge pclk);
        pce <= 1'b1;
        $display("test registers over");
        // Every clock source, both orders, both lengths where time allows
        for (int s = 0; s < 8; s++)
            xfer(s % 2, 3'(s), 8'hC0 | 8'(s < 5 ? $urandom % 2 : 0) << 5 | 8'($urandom % 4) << 3, $urandom, $urandom);
        xfer(0, 3'h0, 8'hA0, 32'h0, $urandom);
        xfer(1, 3'h0, 8'hE4, $urandom, $urandom);
        close_out();
    end
endmodule // testbench
`default_nettype wire
